/* File: logic/camd_pkg.sv */
// package: addressing modes, operation classes, sizes and request structs
package camd_pkg;

  // ****************************************************************
  // widths and limits
  // ****************************************************************
  localparam int unsigned ADDR_W       = 16;
  localparam int unsigned DATA_W       = 8;
  localparam logic [15:0] ZPAGE_MASK   = 16'h00ff;
  localparam logic [15:0] ADDR_ZERO    = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [2:0]  LEN_ONE      = 3'h1;
  localparam logic [2:0]  LEN_STEP     = 3'h1;
  localparam int unsigned MODE_COUNT   = 17;

  // ****************************************************************
  // the seventeen addressing modes
  // ****************************************************************
  typedef enum logic [4:0] {
    AM_INHERENT      = 5'h00,
    AM_IMMEDIATE     = 5'h01,
    AM_DIR_SHORT     = 5'h02,
    AM_DIR_LONG      = 5'h03,
    AM_IDX_NOOFF     = 5'h04,
    AM_IDX_SHORT     = 5'h05,
    AM_IDX_LONG      = 5'h06,
    AM_IND_SHORT     = 5'h07,
    AM_IND_LONG      = 5'h08,
    AM_INDIDX_SHORT  = 5'h09,
    AM_INDIDX_LONG   = 5'h0a,
    AM_REL_DIRECT    = 5'h0b,
    AM_REL_INDIRECT  = 5'h0c,
    AM_BIT_DIRECT    = 5'h0d,
    AM_BIT_INDIRECT  = 5'h0e,
    AM_BIT_DIR_REL   = 5'h0f,
    AM_BIT_IND_REL   = 5'h10
  } camd_mode_e;

  // ****************************************************************
  // operation classes that limit which modes are legal
  // ****************************************************************
  typedef enum logic [1:0] {
    OC_LOAD_ALU = 2'h0,   // load, compare, bit compare, logic, add/sub
    OC_MEM2MEM  = 2'h1,   // clear, complement, shifts, bit ops, inc/dec
    OC_JUMP     = 2'h2,   // call, jump, relative branches
    OC_OTHER    = 2'h3    // inherent-only operations
  } camd_class_e;

  // ****************************************************************
  // decoder states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_FETCH  = 3'h1,
    ST_PTR_RD = 3'h2,
    ST_DISP   = 3'h3,
    ST_DONE   = 3'h4
  } camd_state_e;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    camd_mode_e  mode;
    camd_class_e op_class;
    logic        use_y;       // second index register selected
    logic [2:0]  bit_pos;
    logic [15:0] pc_next;     // address of first byte after opcode
    logic [7:0]  idx_x;
    logic [7:0]  idx_y;
  } camd_req_s;

  typedef struct packed {
    logic [15:0] ea;          // operand address
    logic [7:0]  imm;         // immediate operand
    logic [15:0] target;      // branch target
    logic [2:0]  bit_pos;
    logic [2:0]  length;      // whole instruction length in bytes
    logic        illegal;     // mode not allowed for the class
  } camd_res_s;

  typedef struct packed {
    logic [2:0] operand_bytes; // bytes after opcode (and prefix)
    logic       reads_ptr;
    logic       ptr_word;
    logic       has_disp;      // displacement byte in the stream
    logic       disp_in_mem;   // displacement read through pointer
    logic       indexed;
  } camd_info_s;

endpackage : camd_pkg

/* File: logic/camd_mode_table.sv */
// mode table: operand byte count and fetch shape for each mode
`timescale 1ns/1ps
module camd_mode_table (
  // mode in
  input  wire camd_pkg::camd_mode_e  i_mode,
  input  wire logic                  i_use_y,
  // shape out
  output camd_pkg::camd_info_s       o_info
);

  always_comb begin
    o_info = '0;
    case (i_mode)
      camd_pkg::AM_INHERENT:     o_info.operand_bytes = 3'h0;
      camd_pkg::AM_IMMEDIATE:    o_info.operand_bytes = 3'h1;
      camd_pkg::AM_DIR_SHORT:    o_info.operand_bytes = 3'h1;
      camd_pkg::AM_DIR_LONG:     o_info.operand_bytes = 3'h2;
      camd_pkg::AM_IDX_NOOFF: begin
        // the y form costs one more byte in the stream
        o_info.operand_bytes = i_use_y ? 3'h1 : 3'h0;
        o_info.indexed       = 1'b1;
      end
      camd_pkg::AM_IDX_SHORT: begin
        o_info.operand_bytes = 3'h1;
        o_info.indexed       = 1'b1;
      end
      camd_pkg::AM_IDX_LONG: begin
        o_info.operand_bytes = 3'h2;
        o_info.indexed       = 1'b1;
      end
      camd_pkg::AM_IND_SHORT: begin
        o_info.operand_bytes = 3'h1;
        o_info.reads_ptr     = 1'b1;
      end
      camd_pkg::AM_IND_LONG: begin
        o_info.operand_bytes = 3'h1;
        o_info.reads_ptr     = 1'b1;
        o_info.ptr_word      = 1'b1;
      end
      camd_pkg::AM_INDIDX_SHORT: begin
        o_info.operand_bytes = 3'h1;
        o_info.reads_ptr     = 1'b1;
        o_info.indexed       = 1'b1;
      end
      camd_pkg::AM_INDIDX_LONG: begin
        o_info.operand_bytes = 3'h1;
        o_info.reads_ptr     = 1'b1;
        o_info.ptr_word      = 1'b1;
        o_info.indexed       = 1'b1;
      end
      camd_pkg::AM_REL_DIRECT: begin
        o_info.operand_bytes = 3'h1;
        o_info.has_disp      = 1'b1;
      end
      camd_pkg::AM_REL_INDIRECT: begin
        o_info.operand_bytes = 3'h1;
        o_info.reads_ptr     = 1'b1;
        o_info.disp_in_mem   = 1'b1;
      end
      camd_pkg::AM_BIT_DIRECT:   o_info.operand_bytes = 3'h1;
      camd_pkg::AM_BIT_INDIRECT: begin
        o_info.operand_bytes = 3'h1;
        o_info.reads_ptr     = 1'b1;
      end
      camd_pkg::AM_BIT_DIR_REL: begin
        o_info.operand_bytes = 3'h2;
        o_info.has_disp      = 1'b1;
      end
      camd_pkg::AM_BIT_IND_REL: begin
        o_info.operand_bytes = 3'h2;
        o_info.reads_ptr     = 1'b1;
        o_info.has_disp      = 1'b1;
      end
      default:                   o_info = '0;
    endcase
  end

endmodule : camd_mode_table

/* File: logic/camd_addr_calc.sv */
// address arithmetic: unsigned index add and signed branch offset
`timescale 1ns/1ps
module camd_addr_calc (
  // operands
  input  wire logic [15:0] i_base,
  input  wire logic [7:0]  i_index,
  input  wire logic        i_add_index,
  input  wire logic [15:0] i_pc,
  input  wire logic [7:0]  i_disp,
  // results
  output logic      [15:0] o_ea,
  output logic      [15:0] o_target
);

  logic [15:0] disp_ext;

  always_comb begin
    // zero extend keeps the sum unsigned; short forms top out at 1fe
    o_ea     = i_base + (i_add_index ? {8'h00, i_index} : 16'h0000);
    // sign extend gives -128..+127 around the pc past the branch
    disp_ext = {{8{i_disp[7]}}, i_disp};
    o_target = i_pc + disp_ext;
  end

endmodule : camd_addr_calc

/* File: logic/camd_decoder.sv */
// addressing mode decoder: fetches operand bytes, forms operand address
`timescale 1ns/1ps
module camd_decoder (
  // clock and reset
  input  wire logic                i_clock,
  input  wire logic                i_reset_n,
  // request from the core
  input  wire logic                i_start,
  input  wire camd_pkg::camd_req_s i_req,
  // memory read port, data valid one or more cycles after request, flagged by i_mem_valid
  output logic                     o_mem_rd,
  output logic [15:0]              o_mem_addr,
  input  wire logic [7:0]          i_mem_data,
  input  wire logic                i_mem_valid,
  // result to the core
  output logic                     o_busy,
  output logic                     o_done,
  output camd_pkg::camd_res_s      o_res
);

  // ****************************************************************
  // shape lookup
  // ****************************************************************
  camd_pkg::camd_info_s info;
  camd_pkg::camd_req_s  req_r, req_nxt;

  camd_mode_table camd_mode_table_inst (
    .i_mode (req_r.mode),
    .i_use_y(req_r.use_y),
    .o_info (info)
  );

  // ****************************************************************
  // state
  // ****************************************************************
  camd_pkg::camd_state_e state_r, state_nxt;
  logic [15:0] fetch_addr_r, fetch_addr_nxt; // next stream byte
  logic [15:0] word_r, word_nxt;             // assembled address/offset
  logic [2:0]  left_r, left_nxt;             // stream bytes still owed
  logic [1:0]  pleft_r, pleft_nxt;           // pointer bytes still owed
  logic [15:0] ptr_addr_r, ptr_addr_nxt;
  logic [7:0]  disp_r, disp_nxt;
  logic        pend_r, pend_nxt;             // read outstanding
  logic        mem_rd_r, mem_rd_nxt;
  logic [15:0] mem_addr_r, mem_addr_nxt;
  logic        done_r, done_nxt;
  camd_pkg::camd_res_s res_r, res_nxt;

  logic [15:0] ea;
  logic [15:0] target;
  logic [7:0]  index;
  logic        legal;
  logic [2:0]  extra_len;

  assign index = req_r.use_y ? req_r.idx_y : req_r.idx_x;

  camd_addr_calc camd_addr_calc_inst (
    .i_base     (word_r),
    .i_index    (index),
    .i_add_index(info.indexed),
    .i_pc       (fetch_addr_r),
    .i_disp     (disp_r),
    .o_ea       (ea),
    .o_target   (target)
  );

  // ****************************************************************
  // legality per operation class
  // ****************************************************************
  always_comb begin
    legal = 1'b1;
    case (req_r.op_class)
      camd_pkg::OC_LOAD_ALU:
        legal = !(req_r.mode inside {camd_pkg::AM_REL_DIRECT,
                  camd_pkg::AM_REL_INDIRECT, camd_pkg::AM_BIT_DIRECT,
                  camd_pkg::AM_BIT_INDIRECT, camd_pkg::AM_BIT_DIR_REL,
                  camd_pkg::AM_BIT_IND_REL});

      camd_pkg::OC_MEM2MEM:
        // long forms would need a wider read-modify-write path
        legal = !(req_r.mode inside {camd_pkg::AM_IMMEDIATE,
                  camd_pkg::AM_DIR_LONG, camd_pkg::AM_IDX_LONG,
                  camd_pkg::AM_IND_LONG, camd_pkg::AM_INDIDX_LONG,
                  camd_pkg::AM_REL_DIRECT,
                  camd_pkg::AM_REL_INDIRECT});

      camd_pkg::OC_JUMP:
        legal = (req_r.mode != camd_pkg::AM_IMMEDIATE);

      camd_pkg::OC_OTHER:
        legal = (req_r.mode == camd_pkg::AM_INHERENT);

      default: legal = 1'b0;
    endcase
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    state_nxt      = state_r;
    req_nxt        = req_r;
    fetch_addr_nxt = fetch_addr_r;
    word_nxt       = word_r;
    left_nxt       = left_r;
    pleft_nxt      = pleft_r;
    ptr_addr_nxt   = ptr_addr_r;
    disp_nxt       = disp_r;
    pend_nxt       = pend_r;
    mem_rd_nxt     = 1'b0;
    mem_addr_nxt   = mem_addr_r;
    done_nxt       = 1'b0;
    res_nxt        = res_r;
    extra_len      = 3'h0;

    case (state_r)
      camd_pkg::ST_IDLE: begin
        // no start in the done cycle, the core takes the result first
        if (i_start && !done_r) begin
          req_nxt        = i_req;
          fetch_addr_nxt = i_req.pc_next;
          word_nxt       = camd_pkg::ADDR_ZERO;
          disp_nxt       = camd_pkg::BYTE_ZERO;
          pend_nxt       = 1'b0;
          state_nxt      = camd_pkg::ST_FETCH;
          left_nxt       = 3'h7; // loaded from table next cycle
        end
      end

      camd_pkg::ST_FETCH: begin
        if (left_r == 3'h7) begin
          // a y no-offset prefix-like byte is skipped, not used
          left_nxt  = info.operand_bytes - (info.has_disp ? 3'h1 : 3'h0);
          pleft_nxt = info.ptr_word ? 2'h2 : 2'h1;
          if (req_r.mode == camd_pkg::AM_IDX_NOOFF && req_r.use_y)
            fetch_addr_nxt = fetch_addr_r + 16'h0001;
          if (req_r.mode == camd_pkg::AM_IDX_NOOFF) left_nxt = 3'h0;
        end else if (pend_r) begin
          if (i_mem_valid) begin
            pend_nxt       = 1'b0;
            fetch_addr_nxt = fetch_addr_r + 16'h0001;
            left_nxt       = left_r - 3'h1;
            if (req_r.mode == camd_pkg::AM_REL_DIRECT)
              disp_nxt = i_mem_data;
            else
              word_nxt = {word_r[7:0], i_mem_data};
          end
        end else if (left_r != 3'h0) begin
          mem_rd_nxt   = 1'b1;
          mem_addr_nxt = fetch_addr_r;
          pend_nxt     = 1'b1;
        end else if (info.reads_ptr) begin
          // pointer lives in page zero
          ptr_addr_nxt = word_r & camd_pkg::ZPAGE_MASK;
          word_nxt     = camd_pkg::ADDR_ZERO;
          state_nxt    = camd_pkg::ST_PTR_RD;
        end else if (info.has_disp) begin
          state_nxt = camd_pkg::ST_DISP;
        end else begin
          state_nxt = camd_pkg::ST_DONE;
        end
      end

      camd_pkg::ST_PTR_RD: begin
        if (pend_r) begin
          if (i_mem_valid) begin
            pend_nxt     = 1'b0;
            pleft_nxt    = pleft_r - 2'h1;
            ptr_addr_nxt = ptr_addr_r + 16'h0001;
            if (info.disp_in_mem)
              disp_nxt = i_mem_data;
            else
              word_nxt = {word_r[7:0], i_mem_data};
          end
        end else if (pleft_r != 2'h0) begin
          mem_rd_nxt   = 1'b1;
          mem_addr_nxt = ptr_addr_r;
          pend_nxt     = 1'b1;
        end else if (info.has_disp) begin
          state_nxt = camd_pkg::ST_DISP;
        end else begin
          state_nxt = camd_pkg::ST_DONE;
        end
      end

      camd_pkg::ST_DISP: begin
        // relative direct and test-and-branch forms: displacement is the last stream byte
        if (pend_r) begin
          if (i_mem_valid) begin
            pend_nxt       = 1'b0;
            disp_nxt       = i_mem_data;
            fetch_addr_nxt = fetch_addr_r + 16'h0001;
            state_nxt      = camd_pkg::ST_DONE;
          end
        end else begin
          mem_rd_nxt   = 1'b1;
          mem_addr_nxt = fetch_addr_r;
          pend_nxt     = 1'b1;
        end
      end

      camd_pkg::ST_DONE: begin
        if (req_r.mode == camd_pkg::AM_IDX_NOOFF)
          extra_len = req_r.use_y ? 3'h1 : 3'h0;
        res_nxt.length  = camd_pkg::LEN_ONE + info.operand_bytes;
        res_nxt.bit_pos = req_r.bit_pos;
        res_nxt.illegal = !legal;
        res_nxt.imm     = word_r[7:0];
        res_nxt.target  = target;
        case (req_r.mode)
          camd_pkg::AM_INHERENT, camd_pkg::AM_IMMEDIATE,
          camd_pkg::AM_REL_DIRECT, camd_pkg::AM_REL_INDIRECT:
            res_nxt.ea = camd_pkg::ADDR_ZERO;
          camd_pkg::AM_DIR_SHORT, camd_pkg::AM_IND_SHORT,
          camd_pkg::AM_BIT_DIRECT, camd_pkg::AM_BIT_INDIRECT,
          camd_pkg::AM_BIT_DIR_REL, camd_pkg::AM_BIT_IND_REL:
            res_nxt.ea = word_r & camd_pkg::ZPAGE_MASK;
          camd_pkg::AM_IDX_NOOFF:
            res_nxt.ea = {8'h00, index};
          default:
            res_nxt.ea = ea;
        endcase
        if (extra_len != 3'h0)
          res_nxt.length = camd_pkg::LEN_ONE + camd_pkg::LEN_STEP;
        done_nxt  = 1'b1;
        state_nxt = camd_pkg::ST_IDLE;
      end

      default: state_nxt = camd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r      <= camd_pkg::ST_IDLE;
      req_r        <= '0;
      fetch_addr_r <= camd_pkg::ADDR_ZERO;
      word_r       <= camd_pkg::ADDR_ZERO;
      left_r       <= 3'h0;
      pleft_r      <= 2'h0;
      ptr_addr_r   <= camd_pkg::ADDR_ZERO;
      disp_r       <= camd_pkg::BYTE_ZERO;
      pend_r       <= 1'b0;
      mem_rd_r     <= 1'b0;
      mem_addr_r   <= camd_pkg::ADDR_ZERO;
      done_r       <= 1'b0;
      res_r        <= '0;
    end else begin
      state_r      <= state_nxt;
      req_r        <= req_nxt;
      fetch_addr_r <= fetch_addr_nxt;
      word_r       <= word_nxt;
      left_r       <= left_nxt;
      pleft_r      <= pleft_nxt;
      ptr_addr_r   <= ptr_addr_nxt;
      disp_r       <= disp_nxt;
      pend_r       <= pend_nxt;
      mem_rd_r     <= mem_rd_nxt;
      mem_addr_r   <= mem_addr_nxt;
      done_r       <= done_nxt;
      res_r        <= res_nxt;
    end
  end

  // busy is its own flop, loaded from the next state
  logic busy_r, busy_nxt;
  always_comb begin
    busy_nxt = (state_nxt != camd_pkg::ST_IDLE);
  end
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) busy_r <= 1'b0;
    else            busy_r <= busy_nxt;
  end

  assign o_mem_rd   = mem_rd_r;
  assign o_mem_addr = mem_addr_r;
  assign o_done     = done_r;
  assign o_res      = res_r;
  assign o_busy     = busy_r;

endmodule : camd_decoder

/* File: sim/camd_decoder_props.sv */
// checker: timing and result properties of the mode decoder
`timescale 1ns/1ps
module camd_decoder_props (
  // clock and reset
  input wire logic                i_clock,
  input wire logic                i_reset_n,
  // request and memory
  input wire logic                i_start,
  input wire camd_pkg::camd_req_s i_req,
  input wire logic                o_mem_rd,
  input wire logic [15:0]         o_mem_addr,
  input wire logic [7:0]          i_mem_data,
  input wire logic                i_mem_valid,
  // result
  input wire logic                o_busy,
  input wire logic                o_done,
  input wire camd_pkg::camd_res_s o_res
);
  // ****************************************************************
  // accepted request, kept until the next accepted start
  // ****************************************************************
  camd_pkg::camd_req_s req_r;
  camd_pkg::camd_req_s req_nxt;
  logic                take;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  assign take = i_start && !o_busy && !o_done;
  always_comb begin
    req_nxt = take ? i_req : req_r;
  end
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      req_r <= '0;
    end else begin
      req_r <= req_nxt;
    end
  end
  start_busy_a: assert property (take |=> o_busy)
    else $error("busy did not rise after start");
  done_idle_a: assert property (o_done |=> !o_busy && !o_done)
    else $error("decoder not idle after done");
  rd_pulse_a: assert property (o_mem_rd |-> o_busy ##1 !o_mem_rd)
    else $error("read pulse outside busy or too long");
  inh_one_a: assert property (take
    && i_req.mode == camd_pkg::AM_INHERENT
    |=> !o_mem_rd [*2] ##[1:11] (o_done && o_res.length == 3'h1))
    else $error("inherent read memory or length wrong");
  zero_page_a: assert property (o_done && !o_res.illegal
    && req_r.mode inside {camd_pkg::AM_DIR_SHORT, camd_pkg::AM_IND_SHORT,
    camd_pkg::AM_BIT_DIRECT, camd_pkg::AM_BIT_INDIRECT}
    |-> o_res.ea[15:8] == 8'h00)
    else $error("short form left the zero page");
  imm_legal_a: assert property (o_done
    && req_r.mode == camd_pkg::AM_IMMEDIATE
    |-> o_res.illegal == (req_r.op_class != camd_pkg::OC_LOAD_ALU))
    else $error("immediate legality wrong");
  m2m_short_a: assert property (o_done
    && req_r.op_class == camd_pkg::OC_MEM2MEM
    && req_r.mode inside {camd_pkg::AM_DIR_LONG, camd_pkg::AM_IDX_LONG,
    camd_pkg::AM_IND_LONG, camd_pkg::AM_INDIDX_LONG} |-> o_res.illegal)
    else $error("long form accepted for memory operation");
  noofs_ea_a: assert property (o_done
    && req_r.mode == camd_pkg::AM_IDX_NOOFF
    |-> o_res.ea == {8'h00, req_r.use_y ? req_r.idx_y : req_r.idx_x}
    && o_res.length == (req_r.use_y ? 3'h2 : 3'h1))
    else $error("no offset index result wrong");
  bit_pos_a: assert property (o_done && req_r.mode inside
    {camd_pkg::AM_BIT_DIRECT, camd_pkg::AM_BIT_INDIRECT,
    camd_pkg::AM_BIT_DIR_REL, camd_pkg::AM_BIT_IND_REL}
    |-> o_res.bit_pos == req_r.bit_pos)
    else $error("bit position not passed");
endmodule : camd_decoder_props
bind camd_decoder camd_decoder_props camd_decoder_props_inst (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_start(i_start),
  .i_req(i_req), .o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr),
  .i_mem_data(i_mem_data), .i_mem_valid(i_mem_valid), .o_busy(o_busy),
  .o_done(o_done), .o_res(o_res));

/* File: sim/camd_mem_model.sv */
// memory model: answers decoder reads after a prompt or slow delay
`timescale 1ns/1ps
module camd_mem_model (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  // read port
  input  wire logic        i_rd,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_slow,
  output logic      [7:0]  o_data,
  output logic             o_valid
);
  // ****************************************************************
  // contents are a function of the address so the bench can predict
  // ****************************************************************
  logic [1:0]  wait_r;
  logic [15:0] addr_r;
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wait_r  <= 2'h0;
      addr_r  <= 16'h0000;
      o_valid <= 1'b0;
      o_data  <= 8'h00;
    end else begin
      o_valid <= 1'b0;
      o_data  <= ~o_data; // not held once the answer is gone
      if (i_rd && !i_slow) begin
        o_valid <= 1'b1;
        o_data  <= i_addr[7:0] ^ 8'ha5;
      end else if (i_rd) begin
        wait_r <= 2'h2;
        addr_r <= i_addr;
      end else if (wait_r != 2'h0) begin
        wait_r <= wait_r - 2'h1;
        if (wait_r == 2'h1) begin
          o_valid <= 1'b1;
          o_data  <= addr_r[7:0] ^ 8'ha5;
        end
      end
    end
  end
endmodule : camd_mem_model

/* File: sim/camd_decoder_test.sv */
// testbench: drives the mode decoder against the memory model
`timescale 1ns/1ps
module camd_decoder_test;
  logic                i_clock;
  logic                i_reset_n;
  logic                i_start;
  logic                slow;
  camd_pkg::camd_req_s req;
  camd_pkg::camd_res_s r;
  camd_pkg::camd_res_s o_res;
  logic                o_mem_rd;
  logic                i_mem_valid;
  logic                o_busy;
  logic                o_done;
  logic [15:0]         o_mem_addr;
  logic [7:0]          i_mem_data;
  logic [15:0]         p;
  int                  bad_count = 0;
  int                  num_checks = 0;
  camd_decoder camd_decoder_inst (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_start(i_start), .i_req(req), .o_mem_rd(o_mem_rd),
    .o_mem_addr(o_mem_addr), .i_mem_data(i_mem_data),
    .i_mem_valid(i_mem_valid), .o_busy(o_busy), .o_done(o_done),
    .o_res(o_res));
  camd_mem_model camd_mem_model_inst (.i_clock(i_clock),
    .i_reset_n(i_reset_n), .i_rd(o_mem_rd), .i_addr(o_mem_addr),
    .i_slow(slow), .o_data(i_mem_data), .o_valid(i_mem_valid));
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] dm(input logic [15:0] a);
    return a[7:0] ^ 8'ha5;
  endfunction : dm
  function automatic logic [15:0] wd(input logic [15:0] a);
    return {dm(a), dm(a + 16'h0001)};
  endfunction : wd
  function automatic logic [15:0] sx(input logic [7:0] d);
    return {{8{d[7]}}, d};
  endfunction : sx
  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  // poke >= 0 raises a second start while busy, which must be ignored
  task automatic run(input camd_pkg::camd_mode_e m,
                     input camd_pkg::camd_class_e c,
                     input logic [15:0] pc, input int poke);
    int n;
    @(posedge i_clock);
    #1;
    req.mode = m;
    req.op_class = c;
    req.pc_next = pc;
    i_start = 1'b1;
    @(posedge i_clock);
    #1;
    n = 0;
    while (o_done !== 1'b1 && n < 300) begin
      i_start = (n == poke);
      if (n == poke) begin
        req.mode = camd_pkg::AM_INHERENT;
      end
      @(posedge i_clock);
      #1;
      n++;
    end
    i_start = 1'b0;
    check("done", {15'h0, o_done}, 16'h0001);
    r = o_res;
  endtask : run
  task automatic ok(input logic [15:0] ea, input logic [2:0] len);
    check("ea", r.ea, ea);
    check("length", {13'h0, r.length}, {13'h0, len});
    check("illegal", {15'h0, r.illegal}, 16'h0000);
  endtask : ok
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_inh;
    run(camd_pkg::AM_INHERENT, camd_pkg::OC_OTHER, 16'h1234, -1);
    check("length", {13'h0, r.length}, 16'h0001);
    run(camd_pkg::AM_IMMEDIATE, camd_pkg::OC_LOAD_ALU, 16'h1234, -1);
    check("imm", {8'h00, r.imm}, {8'h00, dm(16'h1234)});
    check("length", {13'h0, r.length}, 16'h0002);
    $display("test inherent_immediate done");
  endtask : t_inh
  task automatic t_dir;
    run(camd_pkg::AM_DIR_SHORT, camd_pkg::OC_LOAD_ALU, 16'h1234, -1);
    ok({8'h00, dm(16'h1234)}, 3'h2);
    check("mem_addr", o_mem_addr, 16'h1234);
    run(camd_pkg::AM_DIR_LONG, camd_pkg::OC_LOAD_ALU, 16'h1234, -1);
    ok(wd(16'h1234), 3'h3);
    $display("test direct done");
  endtask : t_dir
  task automatic t_idx;
    run(camd_pkg::AM_IDX_NOOFF, camd_pkg::OC_LOAD_ALU, 16'h1234, -1);
    ok(16'h00ff, 3'h1);
    req.use_y = 1'b1;
    run(camd_pkg::AM_IDX_NOOFF, camd_pkg::OC_LOAD_ALU, 16'h1234, -1);
    ok(16'h003c, 3'h2);
    req.use_y = 1'b0;
    run(camd_pkg::AM_IDX_SHORT, camd_pkg::OC_LOAD_ALU, 16'h205a, -1);
    ok(16'h01fe, 3'h2);
    run(camd_pkg::AM_IDX_LONG, camd_pkg::OC_LOAD_ALU, 16'h1234, -1);
    ok(wd(16'h1234) + 16'h00ff, 3'h3);
    $display("test indexed done");
  endtask : t_idx
  task automatic t_ind;
    run(camd_pkg::AM_IND_SHORT, camd_pkg::OC_LOAD_ALU, 16'h1210, -1);
    ok({8'h00, dm(p)}, 3'h2);
    run(camd_pkg::AM_IND_LONG, camd_pkg::OC_LOAD_ALU, 16'h1210, -1);
    ok(wd(p), 3'h2);
    run(camd_pkg::AM_INDIDX_SHORT, camd_pkg::OC_LOAD_ALU, 16'h1210, -1);
    ok({8'h00, dm(p)} + 16'h00ff, 3'h2);
    req.use_y = 1'b1;
    run(camd_pkg::AM_INDIDX_LONG, camd_pkg::OC_LOAD_ALU, 16'h1210, -1);
    ok(wd(p) + 16'h003c, 3'h2);
    req.use_y = 1'b0;
    $display("test indirect done");
  endtask : t_ind
  task automatic t_rel;
    run(camd_pkg::AM_REL_DIRECT, camd_pkg::OC_JUMP, 16'h4025, -1);
    check("target", r.target, 16'h4026 + sx(dm(16'h4025)));
    check("length", {13'h0, r.length}, 16'h0002);
    run(camd_pkg::AM_REL_INDIRECT, camd_pkg::OC_JUMP, 16'h1210, -1);
    check("target", r.target, 16'h1211 + sx(dm(p)));
    $display("test relative done");
  endtask : t_rel
  task automatic t_bit;
    req.bit_pos = 3'h7;
    run(camd_pkg::AM_BIT_DIRECT, camd_pkg::OC_MEM2MEM, 16'h1234, -1);
    ok({8'h00, dm(16'h1234)}, 3'h2);
    check("bit_pos", {13'h0, r.bit_pos}, 16'h0007);
    run(camd_pkg::AM_BIT_INDIRECT, camd_pkg::OC_MEM2MEM, 16'h1210, -1);
    ok({8'h00, dm(p)}, 3'h2);
    run(camd_pkg::AM_BIT_DIR_REL, camd_pkg::OC_MEM2MEM, 16'h1234, -1);
    ok({8'h00, dm(16'h1234)}, 3'h3);
    check("target", r.target, 16'h1236 + sx(dm(16'h1235)));
    run(camd_pkg::AM_BIT_IND_REL, camd_pkg::OC_MEM2MEM, 16'h1210, -1);
    ok({8'h00, dm(p)}, 3'h3);
    check("target", r.target, 16'h1212 + sx(dm(16'h1211)));
    $display("test bit done");
  endtask : t_bit
  task automatic t_legal;
    camd_pkg::camd_mode_e  ms[6] = '{camd_pkg::AM_IMMEDIATE,
      camd_pkg::AM_IMMEDIATE, camd_pkg::AM_DIR_LONG, camd_pkg::AM_IDX_LONG,
      camd_pkg::AM_IND_LONG, camd_pkg::AM_DIR_SHORT};
    camd_pkg::camd_class_e cs[6] = '{camd_pkg::OC_MEM2MEM,
      camd_pkg::OC_JUMP, camd_pkg::OC_MEM2MEM, camd_pkg::OC_MEM2MEM,
      camd_pkg::OC_MEM2MEM, camd_pkg::OC_MEM2MEM};
    for (int i = 0; i < 6; i++) begin
      run(ms[i], cs[i], 16'h1234, -1);
      check("illegal", {15'h0, r.illegal}, {15'h0, i < 5});
    end
    $display("test legality done");
  endtask : t_legal
  task automatic t_busy;
    slow = 1'b1;
    run(camd_pkg::AM_DIR_LONG, camd_pkg::OC_LOAD_ALU, 16'h1234, 2);
    ok(wd(16'h1234), 3'h3);
    repeat (10) begin
      @(posedge i_clock);
      #1;
      check("extra done", {15'h0, o_done}, 16'h0000);
    end
    slow = 1'b0;
    $display("test busy_slow done");
  endtask : t_busy
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  initial begin
    #20000;
    bad_count++;
    print_verdict;
  end
  initial begin
    i_reset_n = 1'b0;
    i_start = 1'b0;
    slow = 1'b0;
    req = '0;
    req.idx_x = 8'hff;
    req.idx_y = 8'h3c;
    p = {8'h00, dm(16'h1210)};
    repeat (5) @(posedge i_clock);
    #1;
    i_reset_n = 1'b1;
    t_inh;
    t_dir;
    t_idx;
    t_ind;
    t_rel;
    t_bit;
    t_legal;
    t_busy;
    print_verdict;
  end
endmodule : camd_decoder_test
